/* core/sarcc_pkg.sv */
/*
  Constants, state encoding and a bit-mask helper for the conversion control
  of an 8-bit successive-approximation converter with a parallel host port.
  Assumes a single 100 MHz core clock from which the 1 MHz converter clock
  is derived as a one-cycle enable.
*/
// How it works
// RULE_01 - A start pulse with chip select low begins conversion; otherwise ignored.
// RULE_02 - Select and start both falling low resets approximation, shifter, raises done.
// RULE_03 - While select and start are both low, stay reset, no steps.
// RULE_04 - Conversion starts one to eight converter clocks after release; the code starts seven to eight converter clocks after release.
// RULE_05 - Bits decided MSB first: set trial bit, keep or clear by comparator.
// RULE_06 - Result copied to output latch only after all eight bits decided.
// RULE_07 - Completion drives the done flag low.
// RULE_08 - Read with select low raises done flag and drives latch out.
// RULE_09 - A new start during conversion aborts it and starts afresh.
// RULE_10 - Aborted conversion leaves the output latch holding the previous result.
// RULE_11 - Free-running loop via done fed to start, at most 13690 per second; the code repeats every 73 converter clocks, about 13699 per second.
// RULE_12 - Select, start and output enable inputs are all active low.
// RULE_13 - Without a processor, select may be tied low, start pulsed.
// RULE_14 - Output enable held low continuously presents the latest result.
// RULE_15 - Input switching at converter clock start, comparator sampled at its end.
// RULE_16 - Host waits for done low before reading, else gets old data.
// RULE_17 - Data lines high impedance unless select and output enable are low.
`default_nettype none

package sarcc_pkg;

  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned CONV_CLK_HZ = 1_000_000;
  localparam int unsigned CONV_DIV    = CORE_CLK_HZ / CONV_CLK_HZ;

  localparam int          DIV_W       = 7;
  localparam int          RES_W       = 8;
  localparam logic [6:0]  DIV_LAST    = 7'(CONV_DIV - 1);
  localparam logic [6:0]  DIV_RST     = 7'h00;
  localparam logic [2:0]  PHASE_LAST  = 3'h7;
  localparam logic [2:0]  PHASE_RST   = 3'h0;
  localparam logic [2:0]  SYNC_LAST   = 3'h7;
  localparam logic [2:0]  BIT_MSB     = 3'h7;
  localparam logic [2:0]  BIT_LSB     = 3'h0;
  localparam logic [7:0]  APPROX_RST  = 8'h00;
  localparam logic [7:0]  LATCH_RST   = 8'h00;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'b00001,
    ST_HOLD = 5'b00010,
    ST_SYNC = 5'b00100,
    ST_CONV = 5'b01000,
    ST_LOAD = 5'b10000
  } sarcc_state_t;

  function automatic logic [7:0] sarcc_bit_mask(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction : sarcc_bit_mask

endpackage : sarcc_pkg

`default_nettype wire

/* core/sarcc_top.sv */
/*
  Conversion control of an 8-bit successive-approximation converter: host
  strobes, reset state, start synchronisation, bit-by-bit approximation,
  output latch, completion flag and three-state data enables.
  Assumes host inputs are synchronous to core_clk and that the analog
  comparator answers on comparator_hi before the end of each converter clock.
*/
`default_nettype none

module sarcc_top
  import sarcc_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             chip_select_n,
  input  wire logic             start_strobe_n,
  input  wire logic             output_enable_n,
  input  wire logic             comparator_hi,
  output var  logic [RES_W-1:0] approx_register,
  output var  logic             sample_switch,
  output var  logic             comparator_strobe,
  output var  logic             conversion_done_n,
  output var  logic [RES_W-1:0] data_out,
  output var  logic             data_oe_n
);

  sarcc_state_t     state_r;
  sarcc_state_t     state_nxt;
  logic [DIV_W-1:0] div_r;
  logic [2:0]       sync_ph_r;
  logic [2:0]       phase_r;
  logic [2:0]       bit_idx_r;
  logic [RES_W-1:0] approx_r;
  logic [RES_W-1:0] latch_r;
  logic             hold_prev_r;
  logic             done_n_r;
  logic [RES_W-1:0] data_out_r;
  logic             data_oe_n_r;
  logic             sample_switch_r;
  logic             comparator_strobe_r;

  wire              tick;
  wire              hold;
  wire              hold_rise;
  wire              read_req;
  wire              in_conv;
  wire              bit_end;
  wire              bit_start;
  wire              last_bit;
  wire              sync_go;
  wire [RES_W-1:0]  decided;
  wire [RES_W-1:0]  next_trial;

  assign tick       = (div_r == DIV_LAST);
  assign hold       = !chip_select_n && !start_strobe_n;   // RULE_12
  assign hold_rise  = hold && !hold_prev_r;                // RULE_02
  assign read_req   = !chip_select_n && !output_enable_n;  // RULE_12
  assign in_conv    = (state_r == ST_CONV);
  assign bit_start  = tick && in_conv && (phase_r == PHASE_RST);
  assign bit_end    = tick && in_conv && (phase_r == PHASE_LAST);
  assign last_bit   = (bit_idx_r == BIT_LSB);
  assign sync_go    = tick && (sync_ph_r == SYNC_LAST);
  // The trial bit stays only when the input is at or above the trial level.
  assign decided    = comparator_hi ? approx_r : (approx_r & ~sarcc_bit_mask(bit_idx_r));  // RULE_05
  assign next_trial = decided | sarcc_bit_mask(bit_idx_r - 3'h1);                          // RULE_05

  // Any state yields to the hold condition, which aborts a running conversion.
  always_comb
  begin
    state_nxt = state_r;
    if (hold)
    begin
      state_nxt = ST_HOLD;                                 // RULE_01 RULE_03 RULE_09
    end
    else
    begin
      unique case (state_r)
        ST_IDLE: state_nxt = ST_IDLE;
        ST_HOLD: state_nxt = ST_SYNC;
        ST_SYNC: state_nxt = sync_go ? ST_CONV : ST_SYNC;  // RULE_04
        ST_CONV: state_nxt = (bit_end && last_bit) ? ST_LOAD : ST_CONV;
        ST_LOAD: state_nxt = tick ? ST_IDLE : ST_LOAD;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_r     <= ST_IDLE;
      div_r       <= DIV_RST;
      sync_ph_r   <= PHASE_RST;
      hold_prev_r <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      div_r       <= tick ? DIV_RST : div_r + 7'h01;
      // Clearing the start counter in the reset state keeps the start at least seven converter clocks away.
      sync_ph_r   <= hold ? PHASE_RST : (tick ? sync_ph_r + 3'h1 : sync_ph_r);  // RULE_02 RULE_04
      hold_prev_r <= hold;
    end
  end

  // Approximation sequencing: eight converter clocks per bit, MSB first.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      approx_r  <= APPROX_RST;
      phase_r   <= PHASE_RST;
      bit_idx_r <= BIT_MSB;
    end
    else if (hold)
    begin
      approx_r  <= APPROX_RST;                             // RULE_02 RULE_03
      phase_r   <= PHASE_RST;                              // RULE_02
      bit_idx_r <= BIT_MSB;
    end
    else if (state_r == ST_SYNC && sync_go)
    begin
      approx_r  <= sarcc_bit_mask(BIT_MSB);                // RULE_05
      phase_r   <= PHASE_RST;
      bit_idx_r <= BIT_MSB;
    end
    else if (bit_end)
    begin
      approx_r  <= last_bit ? decided : next_trial;        // RULE_05
      phase_r   <= PHASE_RST;
      bit_idx_r <= last_bit ? BIT_LSB : bit_idx_r - 3'h1;
    end
    else if (tick && in_conv)
    begin
      phase_r   <= phase_r + 3'h1;
    end
  end

  // Output latch and completion flag; completion wins over a read clear.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      latch_r  <= LATCH_RST;
      done_n_r <= 1'b1;
    end
    else if (hold_rise)
    begin
      done_n_r <= 1'b1;                                    // RULE_02 RULE_10
    end
    else if (state_r == ST_LOAD && tick && !hold)
    begin
      latch_r  <= approx_r;                                // RULE_06 RULE_11
      done_n_r <= 1'b0;                                    // RULE_07
    end
    else if (read_req)
    begin
      done_n_r <= 1'b1;                                    // RULE_08
    end
  end

  // Pin-facing flops: data lines driven only during a read.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      data_out_r          <= LATCH_RST;
      data_oe_n_r         <= 1'b1;
      sample_switch_r     <= 1'b0;
      comparator_strobe_r <= 1'b0;
    end
    else
    begin
      data_out_r          <= latch_r;                      // RULE_14
      data_oe_n_r         <= !read_req;                    // RULE_08 RULE_17
      sample_switch_r     <= bit_start && !hold;           // RULE_15
      comparator_strobe_r <= bit_end && !hold;             // RULE_15
    end
  end

  assign approx_register   = approx_r;
  assign sample_switch     = sample_switch_r;
  assign comparator_strobe = comparator_strobe_r;
  assign conversion_done_n = done_n_r;
  assign data_out          = data_out_r;
  assign data_oe_n         = data_oe_n_r;

endmodule : sarcc_top

`default_nettype wire

/* verif/sarcc_cmp_model.sv */
/*
  Analog comparator stand-in: reports whether the input level is at or above
  the trial code. Assumes the level is held steady during a conversion.
*/
`default_nettype none
module sarcc_cmp_model
(
  input  wire logic [7:0] level,
  input  wire logic [7:0] trial,
  output var  logic       hi
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb hi = level >= trial;
endmodule : sarcc_cmp_model
`default_nettype wire

/* verif/sarcc_top_asserts.sv */
/*
  Port checker for the conversion control.
  Assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module sarcc_top_asserts
  import sarcc_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             reset_n,
  input wire logic             chip_select_n,
  input wire logic             start_strobe_n,
  input wire logic             output_enable_n,
  input wire logic [RES_W-1:0] approx_register,
  input wire logic             sample_switch,
  input wire logic             comparator_strobe,
  input wire logic             conversion_done_n,
  input wire logic [RES_W-1:0] data_out,
  input wire logic             data_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire hold = !chip_select_n && !start_strobe_n;
  wire rd   = !chip_select_n && !output_enable_n;
  property p_hold; hold |=> conversion_done_n && approx_register == 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("hold did not reset");
  property p_rd; rd |=> !data_oe_n; endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_nord; !rd |=> data_oe_n; endproperty
  a_nord: assert property (p_nord) else $error("drive outside read");
  property p_rddone; rd |=> conversion_done_n || $fell(conversion_done_n); endproperty
  a_rddone: assert property (p_rddone) else $error("read kept flag low");
  property p_latch; !$stable(data_out) |-> $past(conversion_done_n, 2) && !$past(conversion_done_n); endproperty
  a_latch: assert property (p_latch) else $error("latch moved early");
  property p_strb; comparator_strobe |=> !comparator_strobe; endproperty
  a_strb: assert property (p_strb) else $error("strobe too long");
  property p_first; approx_register == 8'h80 && $past(approx_register) == 8'h00 |-> ##100 sample_switch; endproperty
  a_first: assert property (p_first) else $error("no sample switch");
  property p_sync; hold ##1 !hold |-> ##[1:810] approx_register == 8'h80; endproperty
  a_sync: assert property (p_sync) else $error("start too late");
endmodule : sarcc_top_asserts
bind sarcc_top sarcc_top_asserts chk_u (.core_clk, .reset_n, .chip_select_n, .start_strobe_n, .output_enable_n,
  .approx_register, .sample_switch, .comparator_strobe, .conversion_done_n, .data_out, .data_oe_n);
`default_nettype wire

/* verif/testbench.sv */
/*
  Self-checking bench for the conversion control.
  Assumes the comparator model and the bound checker.
*/
`default_nettype none
module testbench
  import sarcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, cs_n = 1, st_r = 1, oe_n = 1, free = 0, hi, done_n, doe_n;
  logic [7:0] lvl = 8'h00;
  wire [7:0] appr, dout;
  wire st_n = free ? done_n : st_r;
  int err_count = 0, cmp_count = 0, cyc = 0, t;
  sarcc_cmp_model cmp_u (.level(lvl), .trial(appr), .hi(hi));
  sarcc_top dut_u (.core_clk(clk), .reset_n(rst_n), .chip_select_n(cs_n), .start_strobe_n(st_n),
    .output_enable_n(oe_n), .comparator_hi(hi), .approx_register(appr), .sample_switch(),
    .comparator_strobe(), .conversion_done_n(done_n), .data_out(dout), .data_oe_n(doe_n));
  initial forever #5 clk = ~clk;
  task finish_test();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      finish_test();
    end
  end
  task chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task cy(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cy
  task wait_done();
    t = 0;
    while (done_n !== 1'b0 && t < 8000)
    begin
      cy(1);
      t++;
    end
  endtask : wait_done
  task start();
    cs_n = 0;
    st_r = 0;
    cy(2);
    st_r = 1;
    cs_n = 1;
  endtask : start
  task read_chk(logic [7:0] e);
    cs_n = 0;
    oe_n = 0;
    cy(2);
    chk("data_oe_n", 8'h00, 8'(doe_n));
    chk("data_out", e, dout);
    chk("done_n", 8'h01, 8'(done_n));
    oe_n = 1;
    cs_n = 1;
    cy(2);
  endtask : read_chk
  task t_ignore();
    st_r = 0;
    cy(2);
    st_r = 1;
    cy(1000);
    chk("approx", 8'h00, appr);
    chk("ign_done", 8'h01, 8'(done_n));
  endtask : t_ignore
  task t_conv(logic [7:0] v);
    lvl = v;
    start();
    wait_done();
    chk("conv_time", 8'h01, 8'(t >= 6590 && t <= 7310));
    read_chk(v);
  endtask : t_conv
  task t_abort();
    lvl = 8'h5a;
    start();
    cy(3000);
    lvl = 8'h3c;
    start();
    cy(3000);
    chk("kept", 8'ha5, dout);
    wait_done();
    read_chk(8'h3c);
  endtask : t_abort
  task t_free();
    lvl = 8'h81;
    cs_n = 0;
    st_r = 0;
    cy(2);
    st_r = 1;
    oe_n = 0;
    free = 1;
    wait_done();
    cy(20);
    wait_done();
    chk("period", 8'h01, 8'(t + 20 >= 6600));
    chk("free_data", 8'h81, dout);
    chk("free_oe", 8'h00, 8'(doe_n));
    free = 0;
    cs_n = 1;
    oe_n = 1;
  endtask : t_free
  initial
  begin
    cy(8);
    rst_n = 1;
    chk("rst_done", 8'h01, 8'(done_n));
    t_ignore();
    t_conv(8'h00);
    t_conv(8'hff);
    t_conv(8'ha5);
    t_abort();
    t_free();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
